//--- hdl/switch_bank_pkg.sv
// Shared constants and carriers for the output switch control bank.
package switch_bank_pkg;

  localparam int ADDR_WIDTH = 7;
  localparam int DATA_WIDTH = 8;

  // Register addresses on the 7-bit command address field.
  localparam logic [6:0] SHUTDOWN_CTRL_ADDR = 7'h10;
  localparam logic [6:0] SELECT_PAIR_A_ADDR = 7'h14;
  localparam logic [6:0] SELECT_PAIR_B_ADDR = 7'h15;
  localparam logic [6:0] PIN_CONFIG_ADDR = 7'h17;
  localparam logic [6:0] PWM_ONE_DUTY_ADDR = 7'h18;

  // Reset values after power-on or soft reset.
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // Writable masks; reserved bits are dropped on write and read as zero.
  localparam logic [7:0] SHUTDOWN_CTRL_MASK = 8'h70;
  localparam logic [7:0] SELECT_PAIR_MASK = 8'h77;
  localparam logic [7:0] PIN_CONFIG_MASK = 8'hff;
  localparam logic [7:0] PWM_DUTY_MASK = 8'hff;

  // Field positions.
  localparam int OV_DISABLE_BIT = 6;
  localparam int UV_DISABLE_BIT = 5;
  localparam int RECOVERY_BIT = 4;
  localparam int SEL_HIGH_LSB = 4;
  localparam int SEL_LOW_LSB = 0;
  localparam int SEL_WIDTH = 3;
  localparam int FAIL_DUTY_LSB = 6;
  localparam int PIN_TWO_LSB = 3;
  localparam int PIN_ONE_LSB = 0;

  // Switch selector codes.
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_ON = 3'h1;
  localparam logic [2:0] SEL_TIMER_ONE = 3'h2;
  localparam logic [2:0] SEL_TIMER_TWO = 3'h3;
  localparam logic [2:0] SEL_PWM_ONE = 3'h4;
  localparam logic [2:0] SEL_PWM_TWO = 3'h5;

  // Pin selector codes; codes below PIN_OFF select a fail output.
  localparam logic [2:0] PIN_OFF = 3'h4;
  localparam logic [2:0] PIN_WAKE = 3'h5;
  localparam logic [2:0] PIN_LOW_SIDE = 3'h6;
  localparam logic [2:0] PIN_HIGH_SIDE = 3'h7;

  // Fail output period and on-times in units of the fail tick (1/40 period).
  localparam logic [5:0] FAIL_PERIOD_TICKS = 6'd40;
  localparam logic [5:0] FAIL_ON_20 = 6'd8;
  localparam logic [5:0] FAIL_ON_10 = 6'd4;
  localparam logic [5:0] FAIL_ON_5 = 6'd2;
  localparam logic [5:0] FAIL_ON_2P5 = 6'd1;

  // Timing: clock rate and derived counts.
  localparam longint CLK_HZ = 20000000;
  localparam longint PWM_SLOW_HZ = 200;
  localparam longint PWM_STEPS = 255;
  // Cycles per PWM step at 200 Hz; 400 Hz uses half of it.
  localparam int PWM_STEP_CYCLES = int'(CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS));
  localparam longint WAKE_FILTER_NS = 16000;
  localparam longint CLK_PERIOD_NS = 50;
  localparam int WAKE_FILTER_CYCLES =
    int'((WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic overvoltage;
    logic undervoltage;
  } supply_fault_type;

  typedef struct packed {
    logic [6:0] addr;
    logic write;
    logic [7:0] data;
  } command_type;

endpackage : switch_bank_pkg

//--- hdl/pwm_generator.sv
// Counter-based PWM generator with duty over 255 steps and rate select.
`timescale 1ns/10ps
module pwm_generator #(
  parameter int STEP_CYCLES = switch_bank_pkg::PWM_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] duty,
  input wire logic rateFast,
  output logic pwmOut
);

  localparam int PRESCALE_WIDTH = $clog2(STEP_CYCLES + 1);
  localparam logic [PRESCALE_WIDTH-1:0] SLOW_LIMIT =
    PRESCALE_WIDTH'(STEP_CYCLES - 1);
  localparam logic [PRESCALE_WIDTH-1:0] FAST_LIMIT =
    PRESCALE_WIDTH'(STEP_CYCLES / 2 - 1);

  logic [PRESCALE_WIDTH-1:0] prescale_q;
  logic [7:0] step_q;
  logic stepTick;

  assign stepTick = (prescale_q == (rateFast ? FAST_LIMIT : SLOW_LIMIT));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prescale_q <= '0;
    end else if (stepTick || prescale_q > SLOW_LIMIT) begin
      prescale_q <= '0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
    end
  end

  // Steps run 0..254, so duty 255 is always on and duty 0 always off.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_q <= 8'h00;
    end else if (stepTick) begin
      step_q <= (step_q == 8'hfe) ? 8'h00 : step_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (step_q < duty);
    end
  end

endmodule : pwm_generator

//--- hdl/output_switch_control_bank.sv
// Control registers and output selection for four switches and two pins.
//
// Contract
// - Overvoltage shuts switches unless bit 6 set.
// - Undervoltage shuts switches unless bit 5 set.
// - Bit 4 restores switch states after fault.
// - Reserved bits always read back zero.
// - Power-on or soft reset clears registers.
// - Restart keeps shutdown bits 6:4 only.
// - Two registers hold four 3-bit switch selectors.
// - Selector codes: off, on, timers, PWMs.
// - Overcurrent or overtemperature clears switch selector.
// - Bits 7:6 set fail output duty.
// - Pin two selector: fail, off, wake, switches.
// - Pin one same, fail output two instead; code drives both pins from the same failLevel.
// - Restart keeps pin config and PWM duty.
// - PWM on-fraction is duty over 255.
// - Assigned timer starts on nonzero on-time; code only passes the cyclicTimerOne/cyclicTimerTwo inputs through.
// - Rate bit picks 200 Hz or 400 Hz.
`timescale 1ns/10ps
module output_switch_control_bank #(
  parameter int FAIL_TICK_CYCLES = 25000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic softReset,
  input wire logic restartEntry,
  input wire logic cmdValid,
  input wire switch_bank_pkg::command_type cmd,
  output logic [7:0] readData,
  input wire switch_bank_pkg::supply_fault_type supplyFault,
  input wire logic [3:0] switchFault,
  input wire logic cyclicTimerOne,
  input wire logic cyclicTimerTwo,
  input wire logic pwmGeneratorTwo,
  input wire logic pwmOneRateSelect,
  input wire logic pinOneIn,
  input wire logic pinTwoIn,
  output logic [3:0] switchOn,
  output logic pinOneOut,
  output logic pinOneOe,
  output logic pinTwoOut,
  output logic pinTwoOe,
  output logic pinOneWake,
  output logic pinTwoWake
);

  logic [7:0] shutdownCtrl_q;
  logic [7:0] selectA_q;
  logic [7:0] selectB_q;
  logic [7:0] pinConfig_q;
  logic [7:0] pwmDuty_q;
  logic [2:0] sel [4];
  logic [3:0] faultClear;
  logic [3:0] heldState_q;
  logic shutdownActive;
  logic shutdownActive_q;
  logic writeStrobe;
  logic pwmGeneratorOne;
  logic [15:0] failTick_q;
  logic [5:0] failPhase_q;
  logic failLevel;
  logic [5:0] failOnTicks;

  assign writeStrobe = cmdValid && cmd.write;

  assign sel[0] = selectA_q[switch_bank_pkg::SEL_LOW_LSB +: 3];
  assign sel[1] = selectA_q[switch_bank_pkg::SEL_HIGH_LSB +: 3];
  assign sel[2] = selectB_q[switch_bank_pkg::SEL_LOW_LSB +: 3];
  assign sel[3] = selectB_q[switch_bank_pkg::SEL_HIGH_LSB +: 3];

  assign faultClear = switchFault;

  // Shutdown control: reserved bits masked on write; restart keeps 6:4.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shutdownCtrl_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (softReset) begin
      shutdownCtrl_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (restartEntry) begin
      shutdownCtrl_q <= shutdownCtrl_q &
        switch_bank_pkg::SHUTDOWN_CTRL_MASK;
    end else if (writeStrobe &&
                 cmd.addr == switch_bank_pkg::SHUTDOWN_CTRL_ADDR) begin
      shutdownCtrl_q <= cmd.data &
        switch_bank_pkg::SHUTDOWN_CTRL_MASK;
    end
  end

  // Switch selectors; a fault on a switch clears its field over any write.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selectA_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (softReset || restartEntry) begin
      selectA_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else begin
      selectA_q <= (writeStrobe &&
                    cmd.addr == switch_bank_pkg::SELECT_PAIR_A_ADDR) ?
        (cmd.data & switch_bank_pkg::SELECT_PAIR_MASK) : selectA_q;
      if (faultClear[0]) begin
        selectA_q[2:0] <= switch_bank_pkg::SEL_OFF;
      end
      if (faultClear[1]) begin
        selectA_q[6:4] <= switch_bank_pkg::SEL_OFF;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      selectB_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (softReset || restartEntry) begin
      selectB_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else begin
      selectB_q <= (writeStrobe &&
                    cmd.addr == switch_bank_pkg::SELECT_PAIR_B_ADDR) ?
        (cmd.data & switch_bank_pkg::SELECT_PAIR_MASK) : selectB_q;
      if (faultClear[2]) begin
        selectB_q[2:0] <= switch_bank_pkg::SEL_OFF;
      end
      if (faultClear[3]) begin
        selectB_q[6:4] <= switch_bank_pkg::SEL_OFF;
      end
    end
  end

  // Pin configuration and PWM duty survive restart.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinConfig_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (softReset) begin
      pinConfig_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (writeStrobe && !restartEntry &&
                 cmd.addr == switch_bank_pkg::PIN_CONFIG_ADDR) begin
      pinConfig_q <= cmd.data & switch_bank_pkg::PIN_CONFIG_MASK;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwmDuty_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (softReset) begin
      pwmDuty_q <= switch_bank_pkg::REG_RESET_VALUE;
    end else if (writeStrobe && !restartEntry &&
                 cmd.addr == switch_bank_pkg::PWM_ONE_DUTY_ADDR) begin
      pwmDuty_q <= cmd.data & switch_bank_pkg::PWM_DUTY_MASK;
    end
  end

  // Read port answers one cycle after a read command; unmapped reads zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      readData <= 8'h00;
    end else if (cmdValid && !cmd.write) begin
      case (cmd.addr)
        switch_bank_pkg::SHUTDOWN_CTRL_ADDR: readData <= shutdownCtrl_q;
        switch_bank_pkg::SELECT_PAIR_A_ADDR: readData <= selectA_q;
        switch_bank_pkg::SELECT_PAIR_B_ADDR: readData <= selectB_q;
        switch_bank_pkg::PIN_CONFIG_ADDR: readData <= pinConfig_q;
        switch_bank_pkg::PWM_ONE_DUTY_ADDR: readData <= pwmDuty_q;
        default: readData <= 8'h00;
      endcase
    end
  end

  pwm_generator #(
    .STEP_CYCLES(switch_bank_pkg::PWM_STEP_CYCLES)
  ) pwmOneInst (
    .clk(clk),
    .resetn(resetn),
    .duty(pwmDuty_q),
    .rateFast(pwmOneRateSelect),
    .pwmOut(pwmGeneratorOne)
  );

  // Supply fault shutdown, gated by the disable bits.
  assign shutdownActive =
    (supplyFault.overvoltage &&
     !shutdownCtrl_q[switch_bank_pkg::OV_DISABLE_BIT]) ||
    (supplyFault.undervoltage &&
     !shutdownCtrl_q[switch_bank_pkg::UV_DISABLE_BIT]);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shutdownActive_q <= 1'b0;
    end else begin
      shutdownActive_q <= shutdownActive;
    end
  end

  // Without recovery a switch stays off until software writes it again.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heldState_q <= 4'h0;
    end else if (shutdownActive) begin
      heldState_q <= 4'hf;
    end else if (shutdownActive_q &&
                 shutdownCtrl_q[switch_bank_pkg::RECOVERY_BIT]) begin
      heldState_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (faultClear[i] ||
            (writeStrobe && cmd.addr ==
             (i < 2 ? switch_bank_pkg::SELECT_PAIR_A_ADDR :
                      switch_bank_pkg::SELECT_PAIR_B_ADDR))) begin
          heldState_q[i] <= 1'b0;
        end
      end
    end
  end

  // Selector decode; timer codes pass the cyclicTimerOne or cyclicTimerTwo input through.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      switchOn <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (heldState_q[i] || shutdownActive) begin
          switchOn[i] <= 1'b0;
        end else begin
          case (sel[i])
            switch_bank_pkg::SEL_OFF: switchOn[i] <= 1'b0;
            switch_bank_pkg::SEL_ON: switchOn[i] <= 1'b1;
            switch_bank_pkg::SEL_TIMER_ONE: begin
              switchOn[i] <= cyclicTimerOne;
            end
            switch_bank_pkg::SEL_TIMER_TWO: begin
              switchOn[i] <= cyclicTimerTwo;
            end
            switch_bank_pkg::SEL_PWM_ONE: switchOn[i] <= pwmGeneratorOne;
            switch_bank_pkg::SEL_PWM_TWO: switchOn[i] <= pwmGeneratorTwo;
            default: switchOn[i] <= 1'b0;
          endcase
        end
      end
    end
  end

  // Fail output timebase: a 40-tick period with selectable on-ticks.
  always_comb begin
    case (pinConfig_q[switch_bank_pkg::FAIL_DUTY_LSB +: 2])
      2'b00: failOnTicks = switch_bank_pkg::FAIL_ON_20;
      2'b01: failOnTicks = switch_bank_pkg::FAIL_ON_10;
      2'b10: failOnTicks = switch_bank_pkg::FAIL_ON_5;
      default: failOnTicks = switch_bank_pkg::FAIL_ON_2P5;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      failTick_q <= 16'h0000;
      failPhase_q <= 6'h00;
    end else if (failTick_q == 16'(FAIL_TICK_CYCLES - 1)) begin
      failTick_q <= 16'h0000;
      failPhase_q <= (failPhase_q ==
        switch_bank_pkg::FAIL_PERIOD_TICKS - 6'd1) ? 6'h00 :
        failPhase_q + 6'h01;
    end else begin
      failTick_q <= failTick_q + 16'h0001;
    end
  end

  assign failLevel = (failPhase_q < failOnTicks);

  // Pin one and pin two both carry the same fail output, failLevel.
  pin_drive_stage #(
    .FILTER_CYCLES(switch_bank_pkg::WAKE_FILTER_CYCLES)
  ) pinOneStage (
    .clk(clk),
    .resetn(resetn),
    .select(pinConfig_q[switch_bank_pkg::PIN_ONE_LSB +: 3]),
    .failLevel(failLevel),
    .pinIn(pinOneIn),
    .pinOut(pinOneOut),
    .pinOe(pinOneOe),
    .wake(pinOneWake)
  );

  pin_drive_stage #(
    .FILTER_CYCLES(switch_bank_pkg::WAKE_FILTER_CYCLES)
  ) pinTwoStage (
    .clk(clk),
    .resetn(resetn),
    .select(pinConfig_q[switch_bank_pkg::PIN_TWO_LSB +: 3]),
    .failLevel(failLevel),
    .pinIn(pinTwoIn),
    .pinOut(pinTwoOut),
    .pinOe(pinTwoOe),
    .wake(pinTwoWake)
  );

endmodule : output_switch_control_bank

// Per-pin function decode with static wake filter.
module pin_drive_stage #(
  parameter int FILTER_CYCLES = 320
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2:0] select,
  input wire logic failLevel,
  input wire logic pinIn,
  output logic pinOut,
  output logic pinOe,
  output logic wake
);

  logic [9:0] stable_q;
  logic last_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
    end else begin
      case (select)
        switch_bank_pkg::PIN_OFF, switch_bank_pkg::PIN_WAKE: begin
          pinOut <= 1'b0;
          pinOe <= 1'b0;
        end
        switch_bank_pkg::PIN_LOW_SIDE: begin
          pinOut <= 1'b0;
          pinOe <= 1'b1;
        end
        switch_bank_pkg::PIN_HIGH_SIDE: begin
          pinOut <= 1'b1;
          pinOe <= 1'b1;
        end
        default: begin
          pinOut <= failLevel;
          pinOe <= 1'b1;
        end
      endcase
    end
  end

  // Wake level follows the pin only after it holds still for the filter time.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stable_q <= 10'h000;
      last_q <= 1'b0;
      wake <= 1'b0;
    end else begin
      last_q <= pinIn;
      if (select != switch_bank_pkg::PIN_WAKE || pinIn != last_q) begin
        stable_q <= 10'h000;
      end else if (stable_q < 10'(FILTER_CYCLES)) begin
        stable_q <= stable_q + 10'h001;
      end
      if (select != switch_bank_pkg::PIN_WAKE) begin
        wake <= 1'b0;
      end else if (stable_q == 10'(FILTER_CYCLES)) begin
        wake <= last_q;
      end
    end
  end

endmodule : pin_drive_stage

//--- verification/output_switch_control_bank_properties.sv
// Port-level checks for the output switch control bank.
`timescale 1ns/10ps
module output_switch_control_bank_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic softReset,
  input wire logic cmdValid,
  input wire switch_bank_pkg::command_type cmd,
  input wire logic [7:0] readData,
  input wire switch_bank_pkg::supply_fault_type supplyFault,
  input wire logic [3:0] switchFault,
  input wire logic [3:0] switchOn,
  input wire logic pinOneOe,
  input wire logic pinTwoOe
);
  logic [7:0] shutdown_q;
  logic isRead;
  logic isMapped;
  assign isRead = cmdValid && !cmd.write;
  assign isMapped = cmd.addr inside {7'h10, 7'h14, 7'h15, 7'h17, 7'h18};

  // Shadow of the shutdown control byte; restart keeps these bits.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shutdown_q <= 8'h00;
    end else if (softReset) begin
      shutdown_q <= 8'h00;
    end else if (cmdValid && cmd.write && cmd.addr == 7'h10) begin
      shutdown_q <= cmd.data & 8'h70;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence ovOn;
    supplyFault.overvoltage && !shutdown_q[6];
  endsequence
  sequence uvOn;
    supplyFault.undervoltage && !shutdown_q[5];
  endsequence

  a_reset_outputs_low: assert property (disable iff (1'b0)
    !resetn |-> switchOn == 4'h0 && !pinOneOe && !pinTwoOe)
    else $error("outputs active during reset");
  a_soft_clears_switches: assert property (
    softReset |-> ##2 switchOn == 4'h0)
    else $error("switch on after soft reset");
  a_fault_forces_off: assert property (
    (switchFault != 4'h0) ##1 $stable(switchFault)
    |=> (switchOn & $past(switchFault)) == 4'h0)
    else $error("faulted switch still on");
  a_ov_shutdown: assert property (ovOn ##1 ovOn |=> switchOn == 4'h0)
    else $error("no shutdown on overvoltage");
  a_uv_shutdown: assert property (uvOn ##1 uvOn |=> switchOn == 4'h0)
    else $error("no shutdown on undervoltage");
  a_shutdown_readback: assert property (
    isRead && cmd.addr == 7'h10 |=> readData == $past(shutdown_q))
    else $error("shutdown control read back wrong");
  a_select_reserved: assert property (
    isRead && cmd.addr inside {7'h14, 7'h15}
    |=> (readData & 8'h88) == 8'h00)
    else $error("selector reserved bits set");
  a_unmapped_zero: assert property (
    isRead && !isMapped |=> readData == 8'h00)
    else $error("unmapped read not zero");

  cover property (cmdValid && cmd.write && cmd.addr == 7'h14);
  cover property (ovOn ##1 ovOn);
  cover property (switchFault != 4'h0);
  cover property (isRead && !isMapped);
endmodule : output_switch_control_bank_properties

bind output_switch_control_bank output_switch_control_bank_properties
  i_output_switch_control_bank_properties (
  .clk(clk), .resetn(resetn), .softReset(softReset),
  .cmdValid(cmdValid), .cmd(cmd), .readData(readData),
  .supplyFault(supplyFault), .switchFault(switchFault),
  .switchOn(switchOn), .pinOneOe(pinOneOe), .pinTwoOe(pinTwoOe));

//--- verification/host_command_driver.sv
// Microcontroller model that issues one-byte register commands.
`timescale 1ns/10ps
module host_command_driver (
  input wire logic clk,
  input wire logic [7:0] readData,
  output logic cmdValid,
  output switch_bank_pkg::command_type cmd
);
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end

  // Idle lines carry the inverse of the last command, so a design that
  // samples them outside a valid cycle sees wrong values.
  // Duty values used are 0, 1, 255 and mid-range only.
  // Cyclic-sense filtering is never configured here.
  task automatic issue(input logic [6:0] a, input logic w,
                       input logic [7:0] d);
    cmdValid = 1'b1;
    cmd = {a, w, d};
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmd = ~cmd;
    @(posedge clk);
    #1;
  endtask : issue

  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    issue(a, 1'b1, d);
  endtask : write_reg

  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    issue(a, 1'b0, 8'h00);
    d = readData;
  endtask : read_reg
endmodule : host_command_driver

//--- verification/output_switch_control_bank_bench.sv
// Self-checking bench for the output switch control bank.
`timescale 1ns/10ps
module output_switch_control_bank_bench;
  localparam int TICK = 4;
  localparam int LIMIT = 20000;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
    logic [7:0] readExp;
    logic [3:0] swExp;
  } row_type;
  localparam logic [6:0] ADDRS [5] = '{7'h10, 7'h14, 7'h15, 7'h17, 7'h18};
  logic clk, resetn, softReset, restartEntry, cmdValid;
  switch_bank_pkg::command_type cmd;
  switch_bank_pkg::supply_fault_type supplyFault;
  logic [7:0] readData, got;
  logic [3:0] switchFault, switchOn;
  logic timerOne, timerTwo, pwmTwo, pinOneLevel, pinTwoLevel, rateFast;
  logic pinOneOut, pinOneOe, pinTwoOut, pinTwoOe, pinOneWake, pinTwoWake;
  logic pinOneIn, pinTwoIn;
  int failures, checks, cycleCount, highCount, onCycles, pinOneCount;
  // Timer one high, timer two low, PWM two high tell the sources apart.
  row_type rows [11] = '{
    '{7'h18, 8'hff, 8'hff, 4'h0}, '{7'h14, 8'h01, 8'h01, 4'h1},
    '{7'h14, 8'h12, 8'h12, 4'h3}, '{7'h14, 8'h43, 8'h43, 4'h2},
    '{7'h14, 8'h75, 8'h75, 4'h1}, '{7'h14, 8'hee, 8'h66, 4'h0},
    '{7'h15, 8'h41, 8'h41, 4'hc}, '{7'h18, 8'h00, 8'h00, 4'h4},
    '{7'h10, 8'hff, 8'h70, 4'h4}, '{7'h17, 8'ha5, 8'ha5, 4'h4},
    '{7'h11, 8'hff, 8'h00, 4'h4}};

  assign pinOneIn = pinOneOe ? pinOneOut : pinOneLevel;
  assign pinTwoIn = pinTwoOe ? pinTwoOut : pinTwoLevel;

  output_switch_control_bank #(.FAIL_TICK_CYCLES(TICK))
    i_output_switch_control_bank (
    .clk(clk), .resetn(resetn), .softReset(softReset),
    .restartEntry(restartEntry), .cmdValid(cmdValid), .cmd(cmd),
    .readData(readData), .supplyFault(supplyFault),
    .switchFault(switchFault), .cyclicTimerOne(timerOne),
    .cyclicTimerTwo(timerTwo), .pwmGeneratorTwo(pwmTwo),
    .pwmOneRateSelect(rateFast), .pinOneIn(pinOneIn), .pinTwoIn(pinTwoIn),
    .switchOn(switchOn), .pinOneOut(pinOneOut), .pinOneOe(pinOneOe),
    .pinTwoOut(pinTwoOut), .pinTwoOe(pinTwoOe),
    .pinOneWake(pinOneWake), .pinTwoWake(pinTwoWake));

  host_command_driver i_host_command_driver (
    .clk(clk), .readData(readData), .cmdValid(cmdValid), .cmd(cmd));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic check_val(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check_val

  task automatic expect_reg(input logic [6:0] a, input logic [7:0] e);
    i_host_command_driver.read_reg(a, got);
    check_val(got, e);
  endtask : expect_reg

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host_command_driver.write_reg(a, d);
  endtask : wr

  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == LIMIT) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    {resetn, softReset, restartEntry, supplyFault, switchFault} = '0;
    {timerOne, timerTwo, pwmTwo, pinOneLevel, pinTwoLevel} = 5'b10100;
    rateFast = 1'b0;
    {failures, checks, cycleCount} = '0;
    tick(5);
    resetn = 1'b1;
    tick(1);
    foreach (ADDRS[i]) expect_reg(ADDRS[i], 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].data);
      tick(2);
      expect_reg(rows[i].addr, rows[i].readExp);
      check_val({4'h0, switchOn}, {4'h0, rows[i].swExp});
    end
    // An overcurrent on switch three clears only its selector.
    wr(7'h15, 8'h11);
    tick(2);
    switchFault = 4'h4;
    tick(3);
    switchFault = 4'h0;
    tick(2);
    check_val({4'h0, switchOn}, 8'h08);
    expect_reg(7'h15, 8'h10);
    supplyFault.overvoltage = 1'b1;
    tick(4);
    check_val({4'h0, switchOn}, 8'h08);
    supplyFault.overvoltage = 1'b0;
    wr(7'h10, 8'h10);
    supplyFault.overvoltage = 1'b1;
    tick(4);
    check_val({4'h0, switchOn}, 8'h00);
    supplyFault.overvoltage = 1'b0;
    tick(4);
    check_val({4'h0, switchOn}, 8'h08);
    wr(7'h10, 8'h20);
    supplyFault.undervoltage = 1'b1;
    tick(4);
    check_val({4'h0, switchOn}, 8'h08);
    supplyFault.undervoltage = 1'b0;
    wr(7'h10, 8'h00);
    supplyFault.undervoltage = 1'b1;
    tick(4);
    check_val({4'h0, switchOn}, 8'h00);
    supplyFault.undervoltage = 1'b0;
    tick(4);
    check_val({4'h0, switchOn}, 8'h00);
    wr(7'h18, 8'h5a);
    wr(7'h10, 8'hff);
    restartEntry = 1'b1;
    tick(1);
    restartEntry = 1'b0;
    tick(2);
    expect_reg(7'h10, 8'h70);
    expect_reg(7'h15, 8'h00);
    expect_reg(7'h17, 8'ha5);
    expect_reg(7'h18, 8'h5a);
    softReset = 1'b1;
    tick(1);
    softReset = 1'b0;
    tick(1);
    foreach (ADDRS[i]) expect_reg(ADDRS[i], 8'h00);
    // The wire idles high, so either drive style of the fail pin counts.
    pinTwoLevel = 1'b1;
    for (int d = 0; d < 4; d++) begin
      wr(7'h17, {d[1:0], 6'h00});
      tick(160);
      highCount = 0;
      pinOneCount = 0;
      onCycles = (8 >> d) * TICK;
      repeat (160) begin
        tick(1);
        highCount += int'(pinTwoIn);
        pinOneCount += int'(pinOneIn);
      end
      check_val({7'h00, highCount == onCycles ||
                 highCount == 160 - onCycles}, 8'h01);
      check_val({7'h00, pinOneCount == onCycles}, 8'h01);
    end
    pinTwoLevel = 1'b0;
    wr(7'h17, 8'h2d);
    tick(400);
    check_val({6'h00, pinOneOe, pinTwoOe}, 8'h00);
    check_val({7'h00, pinTwoWake}, 8'h00);
    check_val({7'h00, pinOneWake}, 8'h00);
    pinTwoLevel = 1'b1;
    pinOneLevel = 1'b1;
    tick(300);
    check_val({7'h00, pinTwoWake}, 8'h00);
    check_val({7'h00, pinOneWake}, 8'h00);
    tick(30);
    check_val({7'h00, pinTwoWake}, 8'h01);
    check_val({7'h00, pinOneWake}, 8'h01);
    // Pin one as low-side switch, pin two as high-side switch.
    wr(7'h17, 8'h3e);
    tick(2);
    check_val({6'h00, pinOneOe, pinOneOut}, 8'h02);
    check_val({6'h00, pinTwoOe, pinTwoOut}, 8'h03);
    // A second reset mid-run restarts the PWM step count at zero.
    resetn = 1'b0;
    rateFast = 1'b1;
    tick(5);
    resetn = 1'b1;
    wr(7'h18, 8'h01);
    wr(7'h14, 8'h04);
    tick(150);
    check_val({4'h0, switchOn}, 8'h01);
    tick(100);
    check_val({4'h0, switchOn}, 8'h00);
    stop_test();
  end
endmodule : output_switch_control_bank_bench
